// ===== bt_pkg.sv
// bt_pkg: register map, control field layout and reset values of the basic timer.
// assumes a byte-addressed register port with 32-bit data words.
`default_nettype none
package bt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam int unsigned BT_AW = 8;
  localparam logic [7:0] BT_OFF_COUNT = 8'h00;
  localparam logic [7:0] BT_OFF_PRELOAD = 8'h04;
  localparam logic [7:0] BT_OFF_STATUS = 8'h08;
  localparam logic [7:0] BT_OFF_IRQ_EN = 8'h0C;
  localparam logic [7:0] BT_OFF_CTRL = 8'h10;
  localparam logic [7:0] BT_OFF_IRQ_CLR = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned BT_EVT_BIT = 0;
  localparam int unsigned BT_IEN_BIT = 0;
  localparam int unsigned BT_CTL_ENABLE = 0;
  localparam int unsigned BT_CTL_COUNT_UP = 2;
  localparam int unsigned BT_CTL_AUTO = 3;
  localparam int unsigned BT_CTL_SOFT = 4;
  localparam int unsigned BT_CTL_START = 5;
  localparam int unsigned BT_CTL_RELOAD = 6;
  localparam int unsigned BT_CTL_HALT = 7;
  localparam int unsigned BT_CTL_PRE_LSB = 16;
  localparam int unsigned BT_PRE_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // control word carrier and reset values
  typedef struct packed {
    logic [BT_PRE_W-1:0] prescale;
    logic halt;
    logic start;
    logic auto_restart;
    logic count_up;
    logic enable;
  } bt_ctrl_t;

  localparam bt_ctrl_t BT_CTRL_RST = '0;
  localparam logic [31:0] BT_COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] BT_PRELOAD_RST = 32'h0000_0000;
  localparam logic BT_EVT_RST = 1'b0;
  localparam logic BT_IEN_RST = 1'b0;

endpackage
`default_nettype wire

// ===== bt_prescale.sv
// bt_prescale: clock-enable divider, one tick every (div + 1) clocks.
// assumes clr is a synchronous level from the timer core on the same clock.
`timescale 1ns/100ps
`default_nettype none
module bt_prescale
  import bt_pkg::*;
#(
  parameter int unsigned PW = BT_PRE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clr,
  input wire logic [PW-1:0] div,
  // enable pulse
  output logic tick
);

  logic [PW-1:0] cnt_r;
  logic [PW-1:0] cnt_nxt;

  // tick is combinational so the counter steps in the same cycle
  assign tick = !clr && (cnt_r == div);

  always_comb begin
    if (clr || (cnt_r == div)) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = PW'(cnt_r + 1'b1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== bt_timer.sv
// bt_timer: one basic timer instance, 16 or 32 bit, with its register bank.
// assumes a single-cycle register port: strobes one cycle, read data next cycle.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// - registers at base+00h count, 04h preload, 08h status, 0Ch enable, 10h control.
// - counter advances by hardware and also takes firmware writes.
// - count reads are snapshotted so byte reads see one consistent value.
// - 16-bit build: count bits 31:16 read zero and ignore writes.
// - 32-bit build: all 32 count bits read and write.
// - automatic restart loads the preload value into the counter.
// - preload is counter-wide; upper bits of 16-bit build read zero.
// - limit event sets status bit 0; software clears it by writing.
// - with auto restart event is a one-cycle pulse, otherwise a held level.
// - interrupt enable bit 0 gates forwarding of the event flag.
// - internal reset is system reset or soft reset; all registers default.
// - soft reset bit is write-only and clears itself one cycle later.
// - up count saturates at all ones with event; down count saturates at zero.
// - counter steps on an enable every prescale+1 clocks.
module bt_timer
  import bt_pkg::*;
#(
  parameter int unsigned CNT_W = 32
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // register port
  input wire logic [BT_AW-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // interrupt
  output logic IRQ
);

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic [CNT_W-1:0] preload_r;
  logic [CNT_W-1:0] preload_nxt;
  logic [CNT_W-1:0] snap_r;
  logic [CNT_W-1:0] snap_nxt;
  bt_ctrl_t ctrl_r;
  bt_ctrl_t ctrl_nxt;
  logic evt_r;
  logic evt_nxt;
  logic ien_r;
  logic ien_nxt;
  logic soft_r;
  logic soft_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic tick;
  logic run;
  logic at_limit;
  logic evt_now;
  logic div_clr;
  logic wr_count;
  logic wr_preload;
  logic wr_ctrl;
  logic start_set;
  logic reload_req;
  logic evt_clr;

  ////////////////////////////////////////////////////////////////////////////
  // decode and run conditions
  assign wr_count = WR && (ADDR == BT_OFF_COUNT);
  assign wr_preload = WR && (ADDR == BT_OFF_PRELOAD);
  assign wr_ctrl = WR && (ADDR == BT_OFF_CTRL);
  assign start_set = wr_ctrl && WDATA[BT_CTL_START] && !ctrl_r.start;
  // reload only acts while the start bit is set, halted or disabled included
  assign reload_req = wr_ctrl && WDATA[BT_CTL_RELOAD] && ctrl_r.start;
  assign run = ctrl_r.enable && ctrl_r.start && !ctrl_r.halt;
  assign at_limit = ctrl_r.count_up ? (&count_r) : (count_r == '0);
  assign evt_now = run && tick && at_limit && !soft_r;
  // halt, stop and a fresh start all restart the divider
  assign div_clr = !run || start_set || soft_r;
  assign evt_clr = (WR && (ADDR == BT_OFF_STATUS) && WDATA[BT_EVT_BIT])
                || (WR && (ADDR == BT_OFF_IRQ_CLR) && WDATA[BT_EVT_BIT])
                || start_set;

  bt_prescale #(
    .PW(BT_PRE_W)
  ) u_prescale (
    .clk(CLK_SYS),
    .rst(RST),
    .clr(div_clr),
    .div(ctrl_r.prescale),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter and preload
  always_comb begin
    count_nxt = count_r;
    preload_nxt = preload_r;
    if (soft_r) begin
      count_nxt = CNT_W'(BT_COUNT_RST);
      preload_nxt = CNT_W'(BT_PRELOAD_RST);
    end else begin
      if (wr_preload) begin
        preload_nxt = WDATA[CNT_W-1:0];
      end
      if (wr_count) begin
        count_nxt = WDATA[CNT_W-1:0];
      end else if (reload_req) begin
        count_nxt = preload_r;
      end else if (run && tick) begin
        if (at_limit) begin
          // saturate unless restarting
          if (ctrl_r.auto_restart) begin
            count_nxt = preload_r;
          end
        end else if (ctrl_r.count_up) begin
          count_nxt = CNT_W'(count_r + 1'b1);
        end else begin
          count_nxt = CNT_W'(count_r - 1'b1);
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      count_r <= CNT_W'(BT_COUNT_RST);
      preload_r <= CNT_W'(BT_PRELOAD_RST);
    end else begin
      count_r <= count_nxt;
      preload_r <= preload_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, soft reset, status and enable
  always_comb begin
    ctrl_nxt = ctrl_r;
    soft_nxt = 1'b0;
    evt_nxt = evt_r;
    ien_nxt = ien_r;
    if (soft_r) begin
      ctrl_nxt = BT_CTRL_RST;
      evt_nxt = BT_EVT_RST;
      ien_nxt = BT_IEN_RST;
    end else begin
      if (evt_now && !ctrl_r.auto_restart) begin
        ctrl_nxt.start = 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_nxt.prescale = WDATA[BT_CTL_PRE_LSB +: BT_PRE_W];
        ctrl_nxt.halt = WDATA[BT_CTL_HALT];
        ctrl_nxt.start = WDATA[BT_CTL_START];
        ctrl_nxt.auto_restart = WDATA[BT_CTL_AUTO];
        ctrl_nxt.count_up = WDATA[BT_CTL_COUNT_UP];
        ctrl_nxt.enable = WDATA[BT_CTL_ENABLE];
        soft_nxt = WDATA[BT_CTL_SOFT];
      end
      if (WR && (ADDR == BT_OFF_IRQ_EN)) begin
        ien_nxt = WDATA[BT_IEN_BIT];
      end
      // pulse mode drops the flag on its own after one cycle
      if (evt_clr || ctrl_r.auto_restart) begin
        evt_nxt = 1'b0;
      end
      // a new event wins over any clear in the same cycle
      if (evt_now) begin
        evt_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_r <= BT_CTRL_RST;
      soft_r <= 1'b0;
      evt_r <= BT_EVT_RST;
      ien_r <= BT_IEN_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      soft_r <= soft_nxt;
      evt_r <= evt_nxt;
      ien_r <= ien_nxt;
    end
  end

  assign IRQ = evt_r && ien_r;

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    snap_nxt = soft_r ? '0 : snap_r;
    if (RD) begin
      if (ADDR[BT_AW-1:2] == BT_OFF_COUNT[BT_AW-1:2]) begin
        if (ADDR[1:0] == 2'h0) begin
          // byte 0 freezes the word for the byte reads that follow
          snap_nxt = count_r;
          rdata_nxt = 32'(count_r);
        end else begin
          rdata_nxt = 32'(snap_r) >> {ADDR[1:0], 3'h0};
        end
      end else begin
        unique case (ADDR)
          BT_OFF_PRELOAD: rdata_nxt = 32'(preload_r);
          BT_OFF_STATUS: rdata_nxt[BT_EVT_BIT] = evt_r;
          BT_OFF_IRQ_EN: rdata_nxt[BT_IEN_BIT] = ien_r;
          BT_OFF_CTRL: begin
            rdata_nxt[BT_CTL_PRE_LSB +: BT_PRE_W] = ctrl_r.prescale;
            rdata_nxt[BT_CTL_HALT] = ctrl_r.halt;
            rdata_nxt[BT_CTL_START] = ctrl_r.start;
            rdata_nxt[BT_CTL_AUTO] = ctrl_r.auto_restart;
            rdata_nxt[BT_CTL_COUNT_UP] = ctrl_r.count_up;
            rdata_nxt[BT_CTL_ENABLE] = ctrl_r.enable;
          end
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rdata_r <= 32'h0000_0000;
      snap_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
      snap_r <= snap_nxt;
    end
  end

  assign RDATA = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  AST_CNT_WRITE: assert property (
    wr_count && !soft_r |=> count_r == $past(WDATA[CNT_W-1:0]))
    else $error("count write not taken");
  AST_RESTART_LOAD: assert property (
    evt_now && ctrl_r.auto_restart && !wr_count |=> count_r == $past(preload_r))
    else $error("restart did not load preload");
  AST_EVT_SET: assert property (
    evt_now |=> evt_r ##1 (!evt_r || !ctrl_r.auto_restart || evt_now))
    else $error("limit event flag wrong");
  AST_EVT_LEVEL: assert property (
    evt_r && !ctrl_r.auto_restart && !evt_clr && !wr_ctrl && !soft_r |=> evt_r)
    else $error("level event lost without clear");
  AST_IRQ_GATE: assert property (
    $rose(IRQ) |-> $past(evt_now || (WR && ADDR == BT_OFF_IRQ_EN)))
    else $error("interrupt rose without event or enable");
  AST_IEN_READ: assert property (
    RD && ADDR == BT_OFF_IRQ_EN |=> RDATA == {31'h0, $past(ien_r)})
    else $error("enable readback wrong");
  AST_SOFT_CLEAR: assert property (
    wr_ctrl && WDATA[BT_CTL_SOFT] && !soft_r |=> soft_r ##1 !soft_r)
    else $error("soft reset not one cycle");
  AST_SOFT_DEFAULTS: assert property (
    soft_r |=> count_r == '0 && ctrl_r == BT_CTRL_RST && !evt_r && !ien_r)
    else $error("soft reset left state");
  AST_DOWN_SAT: assert property (
    run && tick && !ctrl_r.count_up && count_r == '0 && !ctrl_r.auto_restart
    && !wr_count && !wr_ctrl |=> count_r == '0)
    else $error("down count passed zero");
  AST_SNAP_BYTE: assert property (
    RD && ADDR == (BT_OFF_COUNT + 8'h01) |=> RDATA == (32'($past(snap_r)) >> 8))
    else $error("byte read not from snapshot");
  AST_UPPER_ZERO: assert property (
    RD && (ADDR == BT_OFF_COUNT || ADDR == BT_OFF_PRELOAD)
    |=> (RDATA >> CNT_W) == 32'h0000_0000)
    else $error("bits above counter width not zero");
  AST_PRESCALE: assert property (
    tick && run && !wr_ctrl && ctrl_r.prescale != 16'h0000 |=> !tick)
    else $error("divided enable ticked twice in a row");
  AST_PRELOAD_WRITE: assert property (
    wr_preload && !soft_r |=> preload_r == $past(WDATA[CNT_W-1:0]))
    else $error("preload write not taken");
  AST_UP_SAT: assert property (
    run && tick && ctrl_r.count_up && (&count_r) && !ctrl_r.auto_restart
    && !wr_count && !wr_ctrl && !soft_r |=> &count_r)
    else $error("up count passed all ones");
  AST_ONESHOT_STOP: assert property (
    evt_now && !ctrl_r.auto_restart && !wr_ctrl |=> !ctrl_r.start && evt_r)
    else $error("one-shot limit did not stop with held flag");
  AST_STATUS_CLR: assert property (
    WR && ADDR == BT_OFF_STATUS && WDATA[BT_EVT_BIT] && !evt_now && !soft_r |=> !evt_r)
    else $error("status write did not clear flag");

  COV_AUTO_EVT: cover property (evt_now && ctrl_r.auto_restart);
  COV_ONESHOT_DONE: cover property (evt_now && !ctrl_r.auto_restart ##1 !ctrl_r.start);
  COV_SOFT: cover property (soft_r);
  COV_PRESCALE_TICK: cover property (tick && run && ctrl_r.prescale != 16'h0000);
  COV_SNAP: cover property (RD && ADDR == BT_OFF_COUNT ##1 RD && ADDR[1:0] != 2'h0);

endmodule
`default_nettype wire

// ===== bt_timer_tb.sv
// bt_timer_tb: self-checking bench, 32-bit and 16-bit timer builds on one register port.
// assumes bt_timer answers reads one cycle after the strobe and never stalls.
`timescale 1ns/100ps
`default_nettype none
module bt_timer_tb;
  import bt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [BT_AW-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, rdata16, r32, r16, v, s32, s16;
  logic irq, irq16;
  logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h24};
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int hi, hi16;
  int seed = 32'hd62d;

  bt_timer #(.CNT_W(32)) dut (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq));
  bt_timer #(.CNT_W(16)) dut16 (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata16), .IRQ(irq16));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus tasks and expectations
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    r32 = rdata;
    r16 = rdata16;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] lo16(input logic [31:0] x);
    return {16'h0000, x[15:0]};
  endfunction

  function automatic logic [31:0] ctl(input logic up, input logic aut, input logic [15:0] pre);
    return ({16'h0000, pre} << BT_CTL_PRE_LSB) | (32'(up) << BT_CTL_COUNT_UP)
      | (32'(aut) << BT_CTL_AUTO) | (32'h1 << BT_CTL_START) | 32'h1;
  endfunction

  task automatic end_sim;
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_sim;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    wr_reg(8'h24, 32'hFFFF_FFFF);
    foreach (offs[i]) begin
      rd_reg(offs[i]);
      chk(r32, 32'h0);
      chk(r16, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr_reg(8'h04, v);
      wr_reg(8'h00, ~v);
      rd_reg(8'h04);
      chk(r32, v);
      chk(r16, lo16(v));
      rd_reg(8'h00);
      chk(r32, ~v);
      chk(r16, lo16(~v));
    end
    // one-shot down count ends at zero with a held flag
    wr_reg(8'h00, 32'h5);
    wr_reg(8'h10, ctl(1'b0, 1'b0, 16'h0));
    repeat (20) @(posedge clk_sys);
    rd_reg(8'h00);
    chk(r32, 32'h0);
    chk(r16, 32'h0);
    rd_reg(8'h08);
    chk(r32, 32'h1);
    chk(r16, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr_reg(8'h0C, 32'h1);
    @(posedge clk_sys);
    #1;
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, irq16}, 32'h1);
    wr_reg(8'h08, 32'h1);
    rd_reg(8'h08);
    chk(r32, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // four clocks per step: an off-by-one divider lands outside 89..91
    wr_reg(8'h00, 32'h64);
    wr_reg(8'h10, ctl(1'b0, 1'b0, 16'h3));
    repeat (40) @(posedge clk_sys);
    wr_reg(8'h10, 32'h1);
    rd_reg(8'h00);
    chk(32'(r32 >= 32'h59 && r32 <= 32'h5B), 32'h1);
    // continuous up count wraps to preload once, with a single one-cycle pulse
    wr_reg(8'h04, 32'h40);
    wr_reg(8'h00, 32'hFFFF_FFF0);
    wr_reg(8'h10, ctl(1'b1, 1'b1, 16'h0));
    hi = 0;
    hi16 = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_sys);
      #1;
      hi += int'(irq);
      hi16 += int'(irq16);
    end
    chk(32'(hi), 32'h1);
    chk(32'(hi16), 32'h1);
    wr_reg(8'h10, 32'h1);
    rd_reg(8'h00);
    chk(32'(r32 > 32'h40 && r32 < 32'h80), 32'h1);
    chk(32'(r16 > 32'h40 && r16 < 32'h80), 32'h1);
    // byte reads while running come from the count snapshot
    // live count carries into byte 3 before the lane reads, the snapshot does not
    wr_reg(8'h00, 32'h00FF_FFFE);
    wr_reg(8'h10, ctl(1'b1, 1'b0, 16'h0));
    rd_reg(8'h00);
    s32 = r32;
    s16 = r16;
    for (int k = 1; k < 4; k++) begin
      rd_reg(8'(k));
      chk(r32, s32 >> (8 * k));
      chk(r16, s16 >> (8 * k));
    end
    // soft reset clears the bank, its own bit reads back zero
    wr_reg(8'h04, 32'h123);
    wr_reg(8'h10, 32'h1 << BT_CTL_SOFT);
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      rd_reg(offs[i]);
      chk(r32, 32'h0);
      chk(r16, 32'h0);
    end
    end_sim;
  end
endmodule
`default_nettype wire
